// [inc/mfe_pkg.sv]
// Constants, register map and field positions for the modem front end data port.
// Assumes a 200 MHz system clock and a plain strobe-based register port.
//
// Contract
// R1: Strap low selects half-duplex port, strap high selects full-duplex port.
// R2: Half-duplex: device is slave; full-duplex: device is master and drives timing.
// R3: Half-duplex uses one two-way word bus; full-duplex uses six-bit nibble buses.
// R4: Host clocks equal the oscillator frequency in half-duplex; phase arbitrary.
// R5: Half-duplex format defaults straight binary; transmit and receive switch independently.
// R6: Half-duplex transmit and receive each choose rising or falling clock edge.
// R7: A configuration bit floats the half-duplex bus outputs.
// R8: Bus captures words only with transmit enable high, receive enable low, clock running.
// R9: Host keeps transmit clock running six cycles after transmit enable falls.
// R10: After enable falls, 43 or 96 clocks flush zeros; bus data ignored.
// R11: Device drives bus while receive enable high and clock runs; floats when both low.
// R12: Half-duplex default gain port updates receive gain from upper three bits, mapped.
// R13: Full-duplex words default two's complement; option selects straight binary.
// R14: Full-duplex drives receive clock pin at twice the converter sample rate.
// R15: Full-duplex pairs of nibbles assemble into one word for the interpolator.
// R16: Gain select steers a transmit nibble into the receive gain register.
// R17: Nibbles sampled on internal sampling clock rising edge; buffered copy on pin.
// R18: Nibble with sync low is the upper part; next with sync high the lower.
// R19: One option inverts the sampling clock only; another inverts the pin clock.
// R20: A configuration bit reverses nibble order, first nibble taken as lower part.
// R21: Nibble widths default six and four bits, option five and five, aligned to bit 5.
// R22: While sync stays low, the last transmit word is reused until a new word.
// R23: Mode strap is taken once after reset and held static.
package mfe_pkg;
   // ==========================================================
   // Widths
   localparam int unsigned WORD_W = 12;
   localparam int unsigned NIB_W = 6;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned SYNC_W = 31;
   // ==========================================================
   // Register offsets (byte addresses)
   localparam logic [7:0] OFS_CFG_HD = 8'h00;
   localparam logic [7:0] OFS_CFG_FD = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_LAST_WORD = 8'h0c;
   // ==========================================================
   // Half-duplex configuration fields
   localparam int unsigned HD_TX_TWOS = 0;
   localparam int unsigned HD_RX_TWOS = 1;
   localparam int unsigned HD_TX_FALL = 2;
   localparam int unsigned HD_RX_FALL = 3;
   localparam int unsigned HD_TRISTATE = 4;
   localparam int unsigned HD_INTERP4 = 5;
   localparam int unsigned HD_GAIN_FULL = 6;
   localparam logic [7:0] RST_CFG_HD = 8'h20;
   // ==========================================================
   // Full-duplex configuration fields
   localparam int unsigned FD_STRAIGHT = 0;
   localparam int unsigned FD_TX_INV = 1;
   localparam int unsigned FD_RECEIVE_CLOCK_PIN_INV = 2;
   localparam int unsigned FD_LS_FIRST = 3;
   localparam int unsigned FD_W5 = 4;
   localparam logic [7:0] RST_CFG_FD = 8'h00;
   // ==========================================================
   // Status fields
   localparam int unsigned ST_MODE_FD = 0;
   localparam int unsigned ST_FLUSH = 1;
   localparam int unsigned ST_BUS_OE = 2;
   localparam int unsigned ST_GAIN_LSB = 8;
   // ==========================================================
   // Counts and times
   localparam logic [6:0] FLUSH_2X = 7'h2b;
   localparam logic [6:0] FLUSH_4X = 7'h60;
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned RUN_TIMEOUT_NS = 1000;
   localparam logic [7:0] RUN_CYC = 8'((RUN_TIMEOUT_NS * 1000) / CLK_PERIOD_PS);
   localparam logic [3:0] FD_HALF_CYC = 4'h2;
endpackage

// [hw/mfe_sync.sv]
// Two-stage synchroniser for a vector of independent pin levels.
// Assumes each bit is a level; multi-bit words must be stable around their strobe.
`timescale 1ns/1ps
module mfe_sync
#(
   parameter int unsigned W = 1
)
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // ==========================================================
   // State
   typedef struct packed
   {
      logic [W-1:0] meta;
      logic [W-1:0] held;
   } mfe_sync_st_t;

   mfe_sync_st_t q;
   mfe_sync_st_t d;

   // First stage is read only by the second stage
   always_comb
   begin
      d.meta = d_i;
      d.held = q.meta;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign q_o = q.held;
endmodule

// [hw/mfe_data_port.sv]
// Modem front end data port: half-duplex word bus and full-duplex nibble port.
// Assumes pins arrive asynchronously and the converter side runs on SYS_CLK_I.
//
// The register addresses and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module mfe_data_port
   import mfe_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_I,
   input wire logic MODE_STRAP_I,
   input wire logic [mfe_pkg::ADDR_W-1:0] REG_ADDR_I,
   input wire logic [mfe_pkg::DATA_W-1:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [mfe_pkg::DATA_W-1:0] REG_RDATA_O,
   input wire logic [mfe_pkg::WORD_W-1:0] SHARED_WORD_BUS_I,
   output logic [mfe_pkg::WORD_W-1:0] SHARED_WORD_BUS_O,
   output logic SHARED_WORD_BUS_OE_O,
   input wire logic TRANSMIT_ENABLE_PIN_I,
   input wire logic RECEIVE_ENABLE_PIN_I,
   input wire logic TRANSMIT_CLOCK_PIN_I,
   input wire logic RECEIVE_CLOCK_PIN_I,
   output logic RECEIVE_CLOCK_PIN_O,
   output logic RECEIVE_CLOCK_PIN_OE_O,
   input wire logic [mfe_pkg::NIB_W-1:0] GAIN_CONTROL_PORT_I,
   input wire logic [mfe_pkg::NIB_W-1:0] TX_NIBBLE_I,
   input wire logic TRANSMIT_NIBBLE_SYNC_I,
   input wire logic GAIN_SELECT_I,
   input wire logic [mfe_pkg::WORD_W-1:0] ADC_WORD_I,
   output logic [mfe_pkg::WORD_W-1:0] DAC_WORD_O,
   output logic DAC_VALID_O,
   output logic [mfe_pkg::NIB_W-1:0] RX_GAIN_O,
   output logic FLUSH_ACTIVE_O
);
   import mfe_pkg::*;

   // ==========================================================
   // Functions
   // Internal words are two's complement; straight binary differs in the sign bit
   function automatic logic [WORD_W-1:0] fmt(input logic [WORD_W-1:0] w, input logic twos);
      fmt = twos ? w : {~w[WORD_W-1], w[WORD_W-2:0]};
   endfunction

   function automatic logic edge_of(input logic cur, input logic prev, input logic fall);
      edge_of = fall ? (prev & ~cur) : (cur & ~prev);
   endfunction

   // Three-bit gain code to six-bit gain register, code is gain plus 12 dB
   function automatic logic [NIB_W-1:0] gain_map(input logic [2:0] code);
      case (code)
         3'h0: gain_map = 6'h02;
         3'h1: gain_map = 6'h02;
         3'h2: gain_map = 6'h0a;
         3'h3: gain_map = 6'h12;
         3'h4: gain_map = 6'h1a;
         3'h5: gain_map = 6'h22;
         3'h6: gain_map = 6'h2a;
         default: gain_map = 6'h32;
      endcase
   endfunction

   // Result sits in the top ten bits so both widths keep the sign bit at the top
   function automatic logic [WORD_W-1:0] assemble(input logic [NIB_W-1:0] first,
      input logic [NIB_W-1:0] second, input logic ls_first, input logic w5);
      logic [NIB_W-1:0] msn;
      logic [NIB_W-1:0] lsn;
      msn = ls_first ? second : first;
      lsn = ls_first ? first : second;
      if (w5)
      begin
         assemble = {msn[5:1], lsn[5:1], 2'h0};
      end
      else
      begin
         assemble = {msn[5:0], lsn[5:2], 2'h0};
      end
   endfunction

   // ==========================================================
   // Pin synchronisers
   logic [SYNC_W-1:0] pins_raw;
   logic [SYNC_W-1:0] pins_s;
   logic strap_s;
   logic transmit_enable_pin_s;
   logic receive_enable_pin_s;
   logic transmit_clock_pin_s;
   logic receive_clock_pin_s;
   logic sync_s;
   logic gsel_s;
   logic [NIB_W-1:0] gport_s;
   logic [NIB_W-1:0] nib_s;
   logic [WORD_W-1:0] bus_s;

   assign pins_raw = {SHARED_WORD_BUS_I, TX_NIBBLE_I, GAIN_CONTROL_PORT_I, GAIN_SELECT_I,
      TRANSMIT_NIBBLE_SYNC_I, RECEIVE_CLOCK_PIN_I, TRANSMIT_CLOCK_PIN_I,
      RECEIVE_ENABLE_PIN_I, TRANSMIT_ENABLE_PIN_I, MODE_STRAP_I};

   mfe_sync #(.W(SYNC_W)) u_sync
   (
      .clk_i(SYS_CLK_I),
      .rst_i(RST_I),
      .d_i(pins_raw),
      .q_o(pins_s)
   );

   assign strap_s = pins_s[0];
   assign transmit_enable_pin_s = pins_s[1];
   assign receive_enable_pin_s = pins_s[2];
   assign transmit_clock_pin_s = pins_s[3];
   assign receive_clock_pin_s = pins_s[4];
   assign sync_s = pins_s[5];
   assign gsel_s = pins_s[6];
   assign gport_s = pins_s[12:7];
   assign nib_s = pins_s[18:13];
   assign bus_s = pins_s[30:19];

   // ==========================================================
   // State
   typedef struct packed
   {
      logic [1:0] boot;
      logic mode_ok;
      logic mode_fd;
      logic [7:0] cfg_hd;
      logic [7:0] cfg_fd;
      logic [DATA_W-1:0] rdata;
      logic txc;
      logic rxc;
      logic transmit_enable_pin_p;
      logic flushing;
      logic [6:0] flush_cnt;
      logic [7:0] rx_idle;
      logic [WORD_W-1:0] bus_o;
      logic bus_oe;
      logic [WORD_W-1:0] dac;
      logic dac_v;
      logic [WORD_W-1:0] last_word;
      logic [NIB_W-1:0] first_nib;
      logic have_first;
      logic prev_sync;
      logic [NIB_W-1:0] gain;
      logic [3:0] div;
      logic clk_int;
      logic prev_sclk;
      logic pin_o;
      logic pin_oe;
   } mfe_state_t;

   mfe_state_t q;
   mfe_state_t d;

   logic tx_edge;
   logic rx_edge;
   logic sclk;
   logic s_edge;
   logic [WORD_W-1:0] hd_word;
   logic [WORD_W-1:0] fd_word;

   assign tx_edge = edge_of(transmit_clock_pin_s, q.txc, q.cfg_hd[HD_TX_FALL]); // R6
   assign rx_edge = edge_of(receive_clock_pin_s, q.rxc, q.cfg_hd[HD_RX_FALL]); // R6
   // Sampling clock follows the pin clock, optionally inverted for transmit only
   assign sclk = q.clk_int ^ q.cfg_fd[FD_RECEIVE_CLOCK_PIN_INV] ^ q.cfg_fd[FD_TX_INV]; // R19
   assign s_edge = q.mode_fd & sclk & ~q.prev_sclk; // R17
   assign hd_word = fmt(bus_s, q.cfg_hd[HD_TX_TWOS]); // R5
   assign fd_word = fmt(assemble(q.first_nib, nib_s, q.cfg_fd[FD_LS_FIRST], q.cfg_fd[FD_W5]),
      ~q.cfg_fd[FD_STRAIGHT]); // R13 R15 R18 R20 R21

   // ==========================================================
   // Next state
   always_comb
   begin
      d = q;
      d.dac_v = 1'b0;
      d.rdata = '0;
      d.txc = transmit_clock_pin_s;
      d.rxc = receive_clock_pin_s;
      d.transmit_enable_pin_p = transmit_enable_pin_s;
      d.prev_sclk = sclk;
      // Strap taken once; switching modes mid-traffic would corrupt both paths
      // Synchroniser restarts from zero with reset, so wait until the strap has passed it
      if (!q.mode_ok)
      begin
         if (q.boot == 2'h2)
         begin
            d.mode_ok = 1'b1; // R23
            d.mode_fd = strap_s; // R1
         end
         else
         begin
            d.boot = q.boot + 2'h1;
         end
      end
      if (REG_WR_I)
      begin
         case (REG_ADDR_I)
            OFS_CFG_HD: d.cfg_hd = REG_WDATA_I[7:0];
            OFS_CFG_FD: d.cfg_fd = REG_WDATA_I[7:0];
            default: ;
         endcase
      end
      if (REG_RD_I)
      begin
         case (REG_ADDR_I)
            OFS_CFG_HD: d.rdata = {24'h0, q.cfg_hd};
            OFS_CFG_FD: d.rdata = {24'h0, q.cfg_fd};
            OFS_STATUS:
            begin
               d.rdata[ST_MODE_FD] = q.mode_fd;
               d.rdata[ST_FLUSH] = q.flushing;
               d.rdata[ST_BUS_OE] = q.bus_oe;
               d.rdata[ST_GAIN_LSB +: NIB_W] = q.gain;
            end
            OFS_LAST_WORD: d.rdata = {20'h0, q.dac};
            default: d.rdata = '0;
         endcase
      end
      if (!q.mode_fd)
      begin
         // Half-duplex: host clocks the port, device never drives the clock pin
         d.pin_oe = 1'b0; // R2
         d.pin_o = 1'b0;
         if (tx_edge)
         begin
            if (transmit_enable_pin_s && !receive_enable_pin_s)
            begin
               d.dac = hd_word; // R8
               d.dac_v = 1'b1;
               d.flushing = 1'b0;
            end
            else if (q.flushing)
            begin
               // Bus content is ignored while zeros are pushed through
               d.dac = '0; // R10
               d.dac_v = 1'b1;
               d.flush_cnt = q.flush_cnt - 7'h1;
               if (q.flush_cnt == 7'h1)
               begin
                  d.flushing = 1'b0;
               end
            end
         end
         // Flush length covers the six drain clocks the host supplies as well
         if (q.transmit_enable_pin_p && !transmit_enable_pin_s)
         begin
            d.flushing = 1'b1; // R9 R10
            d.flush_cnt = q.cfg_hd[HD_INTERP4] ? FLUSH_4X : FLUSH_2X;
         end
         if (rx_edge)
         begin
            d.rx_idle = '0;
            if (receive_enable_pin_s)
            begin
               d.bus_o = fmt(ADC_WORD_I, q.cfg_hd[HD_RX_TWOS]); // R5 R11
            end
         end
         else if (q.rx_idle != RUN_CYC)
         begin
            d.rx_idle = q.rx_idle + 8'h1;
         end
         // A stopped receive clock releases the bus so no stale word is held
         d.bus_oe = receive_enable_pin_s && (q.rx_idle != RUN_CYC) && !q.cfg_hd[HD_TRISTATE]; // R3 R7 R11
         if (q.cfg_hd[HD_GAIN_FULL])
         begin
            d.gain = gport_s;
         end
         else
         begin
            d.gain = gain_map(gport_s[5:3]); // R12
         end
      end
      else
      begin
         // Full-duplex: device divides its own clock and drives the pin
         d.bus_oe = 1'b0; // R3
         d.flushing = 1'b0;
         if (q.div == FD_HALF_CYC - 4'h1)
         begin
            d.div = '0;
            d.clk_int = ~q.clk_int; // R14
         end
         else
         begin
            d.div = q.div + 4'h1;
         end
         d.pin_o = d.clk_int ^ q.cfg_fd[FD_RECEIVE_CLOCK_PIN_INV]; // R17 R19
         d.pin_oe = 1'b1; // R2
         if (s_edge)
         begin
            d.prev_sync = sync_s;
            if (gsel_s && !sync_s)
            begin
               d.gain = nib_s; // R16
            end
            else if (!sync_s)
            begin
               if (!q.prev_sync && q.have_first)
               begin
                  d.dac = q.last_word; // R22
                  d.dac_v = 1'b1;
               end
               d.first_nib = nib_s; // R18
               d.have_first = 1'b1;
            end
            else if (q.have_first)
            begin
               d.dac = fd_word; // R15
               d.last_word = fd_word;
               d.dac_v = 1'b1;
               d.have_first = 1'b0;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (RST_I)
      begin
         q <= '0;
         q.cfg_hd <= RST_CFG_HD;
         q.cfg_fd <= RST_CFG_FD;
      end
      else
      begin
         q <= d;
      end
   end

   assign REG_RDATA_O = q.rdata;
   assign SHARED_WORD_BUS_O = q.bus_o;
   assign SHARED_WORD_BUS_OE_O = q.bus_oe;
   assign RECEIVE_CLOCK_PIN_O = q.pin_o;
   assign RECEIVE_CLOCK_PIN_OE_O = q.pin_oe;
   assign DAC_WORD_O = q.dac;
   assign DAC_VALID_O = q.dac_v;
   assign RX_GAIN_O = q.gain;
   assign FLUSH_ACTIVE_O = q.flushing;

   // ==========================================================
   // Checks
   property p_mode_sel;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (!$past(q.mode_ok) && q.mode_ok) |-> (q.mode_fd == $past(strap_s));
   endproperty
   a_mode_sel: assert property (p_mode_sel) else $error("mode not taken from strap"); // R1

   property p_mode_static;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (q.mode_ok && $past(q.mode_ok)) |-> $stable(q.mode_fd);
   endproperty
   a_mode_static: assert property (p_mode_static) else $error("mode changed"); // R23

   property p_clk_master;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (q.mode_ok && $past(q.mode_ok)) |-> (q.pin_oe == q.mode_fd);
   endproperty
   a_clk_master: assert property (p_clk_master) else $error("clock pin drive wrong"); // R2

   property p_fd_toggle;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (q.mode_fd && q.div == FD_HALF_CYC - 4'h1) |=> (q.clk_int != $past(q.clk_int)) ##1
      $stable(q.clk_int);
   endproperty
   a_fd_toggle: assert property (p_fd_toggle) else $error("link clock period wrong"); // R14

   property p_float;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (!transmit_enable_pin_s && !receive_enable_pin_s) |=> !q.bus_oe;
   endproperty
   a_float: assert property (p_float) else $error("bus driven with both enables low"); // R11

   property p_tristate;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      q.cfg_hd[HD_TRISTATE] |=> !q.bus_oe;
   endproperty
   a_tristate: assert property (p_tristate) else $error("bus driven while floated"); // R7

   property p_tx_capture;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (!q.mode_fd && tx_edge && transmit_enable_pin_s && !receive_enable_pin_s) |=> (q.dac_v && q.dac == $past(hd_word));
   endproperty
   a_tx_capture: assert property (p_tx_capture) else $error("transmit word not captured"); // R8

   property p_flush_len;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (!q.mode_fd && q.transmit_enable_pin_p && !transmit_enable_pin_s) |=> (q.flushing &&
      q.flush_cnt == ($past(q.cfg_hd[HD_INTERP4]) ? FLUSH_4X : FLUSH_2X));
   endproperty
   a_flush_len: assert property (p_flush_len) else $error("flush length wrong"); // R10

   property p_hd_gain;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (!q.mode_fd && !q.cfg_hd[HD_GAIN_FULL]) |=> (q.gain == gain_map($past(gport_s[5:3])));
   endproperty
   a_hd_gain: assert property (p_hd_gain) else $error("gain mapping wrong"); // R12

   property p_gain_steer;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (s_edge && gsel_s && !sync_s) |=> (q.gain == $past(nib_s) && !q.dac_v);
   endproperty
   a_gain_steer: assert property (p_gain_steer) else $error("gain nibble leaked"); // R16

   property p_assemble;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (s_edge && sync_s && q.have_first) |=> (q.dac_v && q.dac == $past(fd_word));
   endproperty
   a_assemble: assert property (p_assemble) else $error("word assembly wrong"); // R15

   property p_reuse;
      @(posedge SYS_CLK_I) disable iff (RST_I)
      (s_edge && !sync_s && !gsel_s && !q.prev_sync && q.have_first) |=>
      (q.dac_v && q.dac == $past(q.last_word));
   endproperty
   a_reuse: assert property (p_reuse) else $error("last word not reused"); // R22
endmodule

// [tb/mfe_host_model.sv]
// Host controller model for the data port's far side.
// Assumes one bench process calls its tasks, one at a time.
`timescale 1ns/1ps
module mfe_host_model
(
   input wire logic fd_clk_i,
   output logic tx_clk_o,
   output logic rx_clk_o,
   output logic transmit_enable_pin_o,
   output logic receive_enable_pin_o,
   output logic [11:0] bus_o,
   output logic [5:0] nib_o,
   output logic sync_o,
   output logic gsel_o
);
   initial
   begin
      {tx_clk_o, rx_clk_o, transmit_enable_pin_o, receive_enable_pin_o, sync_o, gsel_o} = 6'h00;
      bus_o = 12'h000;
      nib_o = 6'h00;
   end
   // ========
   // Half-duplex
   task automatic hd_start(input logic tx, input logic rx, input logic [11:0] w);
      bus_o = w;
      transmit_enable_pin_o = tx;
      receive_enable_pin_o = rx;
   endtask
   // Data moves between edges, so rising and falling sampling see different words
   task automatic hd_clk(input int n, input logic [11:0] nxt);
      for (int i = 0; i < n; i++)
      begin
         #62.5 tx_clk_o = 1'b1;
         rx_clk_o = 1'b1;
         #31 bus_o = transmit_enable_pin_o ? nxt : ~bus_o;
         #31.5 tx_clk_o = 1'b0;
         rx_clk_o = 1'b0;
      end
   endtask
   // Clocks keep running afterwards to drain and flush
   task automatic hd_stop();
      #20 transmit_enable_pin_o = 1'b0;
      receive_enable_pin_o = 1'b0;
   endtask
   // ========
   // Full-duplex: change just after the device clock rises
   task automatic fd_nib(input logic [5:0] n, input logic s, input logic g);
      @(posedge fd_clk_i);
      #1 nib_o = n;
      sync_o = s;
      gsel_o = g;
   endtask
endmodule

// [tb/mfe_data_port_tb.sv]
// Self-checking bench for the data port.
// Assumes mfe_pkg and the host model are compiled first.
`timescale 1ns/1ps
module mfe_data_port_tb;
   import mfe_pkg::*;
   typedef struct packed {
      logic [7:0] cfg;
      logic tx;
      logic rx;
      logic [11:0] w;
      logic [11:0] exp;
      logic oe;
   } mfe_row_t;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [5:0] gain = 6'h00;
   logic [11:0] adc = 12'h5a6;
   logic [31:0] rdata;
   logic [11:0] bus_o, dac, hbus;
   logic bus_oe, rclk_o, rclk_oe, dac_v, flush;
   logic [5:0] rx_gain, nib;
   logic tclk, hclk, transmit_enable_pin, receive_enable_pin, sync, gsel;
   logic [11:0] words[$];
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   mfe_row_t rows[8] = '{
      '{8'h00, 1'b1, 1'b0, 12'h123, 12'h923, 1'b0},
      '{8'h01, 1'b1, 1'b0, 12'h123, 12'h123, 1'b0},
      '{8'h04, 1'b1, 1'b0, 12'h123, 12'h6dc, 1'b0},
      '{8'h20, 1'b1, 1'b0, 12'h7ff, 12'hfff, 1'b0},
      '{8'h02, 1'b0, 1'b1, 12'h000, 12'h5a6, 1'b1},
      '{8'h00, 1'b0, 1'b1, 12'h000, 12'hda6, 1'b1},
      '{8'h10, 1'b0, 1'b1, 12'h000, 12'h000, 1'b0},
      '{8'h00, 1'b1, 1'b1, 12'h000, 12'hda6, 1'b1}};
   logic [7:0] fcfg[4] = '{8'h00, 8'h01, 8'h08, 8'h10};
   logic [5:0] n1[4] = '{6'h2b, 6'h2b, 6'h3c, 6'h2b};
   logic [5:0] n2[4] = '{6'h3c, 6'h3c, 6'h2b, 6'h3c};
   logic [11:0] fexp[4] = '{12'hafc, 12'h2fc, 12'hafc, 12'haf8};
   logic [5:0] gmap[8] = '{6'h02, 6'h02, 6'h0a, 6'h12, 6'h1a, 6'h22, 6'h2a, 6'h32};
   wire [11:0] bus_i = bus_oe ? bus_o : hbus;
   wire rclk_i = rclk_oe ? rclk_o : hclk;
   always #2.5 clk = ~clk;
   mfe_data_port mfe_data_port_i (.SYS_CLK_I(clk), .RST_I(rst), .MODE_STRAP_I(strap),
      .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd),
      .REG_RDATA_O(rdata), .SHARED_WORD_BUS_I(bus_i), .SHARED_WORD_BUS_O(bus_o),
      .SHARED_WORD_BUS_OE_O(bus_oe), .TRANSMIT_ENABLE_PIN_I(transmit_enable_pin),
      .RECEIVE_ENABLE_PIN_I(receive_enable_pin), .TRANSMIT_CLOCK_PIN_I(tclk), .RECEIVE_CLOCK_PIN_I(rclk_i),
      .RECEIVE_CLOCK_PIN_O(rclk_o), .RECEIVE_CLOCK_PIN_OE_O(rclk_oe),
      .GAIN_CONTROL_PORT_I(gain), .TX_NIBBLE_I(nib), .TRANSMIT_NIBBLE_SYNC_I(sync),
      .GAIN_SELECT_I(gsel), .ADC_WORD_I(adc), .DAC_WORD_O(dac), .DAC_VALID_O(dac_v),
      .RX_GAIN_O(rx_gain), .FLUSH_ACTIVE_O(flush));
   mfe_host_model mfe_host_model_i (.fd_clk_i(rclk_i), .tx_clk_o(tclk), .rx_clk_o(hclk),
      .transmit_enable_pin_o(transmit_enable_pin), .receive_enable_pin_o(receive_enable_pin), .bus_o(hbus), .nib_o(nib), .sync_o(sync),
      .gsel_o(gsel));
   // ========
   // Checking and register tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         num_errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   // Word monitor and hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (dac_v === 1'b1)
         words.push_back(dac);
      if (cyc == 60000)
      begin
         num_errors++;
         summarize();
      end
   end
   // ========
   // Main sequence
   initial
   begin
      logic [31:0] d;
      time t0;
      int n0;
      logic [11:0] prev;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      reg_read(OFS_CFG_HD, d);
      chk(d, 32'(RST_CFG_HD));
      reg_read(OFS_CFG_FD, d);
      chk(d, 32'(RST_CFG_FD));
      reg_write(8'h40, 32'hff);
      reg_read(8'h40, d);
      chk(d, 32'h0);
      reg_read(OFS_STATUS, d);
      chk(32'(d[ST_MODE_FD]), 32'h0);
      for (int c = 0; c < 8; c++)
      begin
         gain <= 6'(c << 3);
         repeat (6) @(posedge clk);
         chk(32'(rx_gain), 32'(gmap[c]));
      end
      for (int r = 0; r < 8; r++)
      begin
         reg_write(OFS_CFG_HD, 32'(rows[r].cfg));
         words.delete();
         mfe_host_model_i.hd_start(rows[r].tx, rows[r].rx, rows[r].w);
         mfe_host_model_i.hd_clk(1, ~rows[r].w);
         repeat (8) @(posedge clk);
         chk(32'(bus_oe), 32'(rows[r].oe));
         if (rows[r].oe)
            chk(32'(bus_o), 32'(rows[r].exp));
         mfe_host_model_i.hd_stop();
         repeat (8) @(posedge clk);
         chk(32'(bus_oe), 32'h0);
         mfe_host_model_i.hd_clk(100, 12'h000);
         repeat (8) @(posedge clk);
         if (rows[r].tx && !rows[r].rx)
         begin
            chk(32'(words.size()), rows[r].cfg[HD_INTERP4] ? 32'd97 : 32'd44);
            chk(32'(words[0]), 32'(rows[r].exp));
            chk(32'(words[$]), 32'h0);
         end
         else
            chk(32'(words.or()), 32'h0);
      end
      // A strap change without reset must not switch modes
      strap <= 1'b1;
      repeat (6) @(posedge clk);
      reg_read(OFS_STATUS, d);
      chk(32'(d[ST_MODE_FD]), 32'h0);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      reg_read(OFS_STATUS, d);
      chk(32'(d[ST_MODE_FD]), 32'h1);
      @(posedge rclk_i);
      t0 = $time;
      @(posedge rclk_i);
      chk(32'($time - t0), 32'd20);
      chk(32'(rclk_oe), 32'h1);
      mfe_host_model_i.fd_nib(6'h00, 1'b1, 1'b0);
      for (int c = 0; c < 4; c++)
      begin
         reg_write(OFS_CFG_FD, 32'(fcfg[c]));
         mfe_host_model_i.fd_nib(n1[c], 1'b0, 1'b0);
         mfe_host_model_i.fd_nib(n2[c], 1'b1, 1'b0);
         repeat (4) @(posedge rclk_i);
         chk(32'(words[$]), 32'(fexp[c]));
      end
      n0 = words.size();
      repeat (3) mfe_host_model_i.fd_nib(6'h15, 1'b0, 1'b1);
      mfe_host_model_i.fd_nib(6'h15, 1'b1, 1'b0);
      repeat (4) @(posedge rclk_i);
      chk(32'(rx_gain), 32'h15);
      chk(32'(words.size()), 32'(n0));
      prev = words[$];
      n0 = words.size();
      repeat (3) mfe_host_model_i.fd_nib(6'h01, 1'b0, 1'b0);
      repeat (4) @(posedge rclk_i);
      chk(32'(words.size() > n0), 32'h1);
      chk(32'(words[$]), 32'(prev));
      summarize();
   end
endmodule
